/* File: logic/ptoc_map.svh */
// Function
// - Critical current event after selected deglitch: 10, 100, 400 or 800 us.
// - Critical threshold code 2 to 25 in 5% steps of limit, 26 to 30 in 50% steps; 0,1 give 110%; 31 invalid.
// - Limit above 3.584 A clamps critical threshold at 230%.
// - Overcurrent level is 125% of critical when bit 0, 200% when 1.
// - System voltage compare uses a fixed 20 us deglitch.
// - System voltage event below level chosen per code and cell count.
// - Extension on holds throttle low until host clear; else width field.
// - Without extension each throttle pulse lasts at least selected width.
// - In extension, host writing 0 to clear bit ends pulse; 1 is idle.
// - Nominal threshold 10% above limit, deglitch at most 1 ms or 50 ms.
// - Throttle only from enabled sources; all enables zero disables it.
//
// Purpose: Offsets, field positions, reset values and timings of the block
// Assumes: Clock at 200 MHz
// Notes:   Definitions only
`ifndef PTOC_MAP_SVH
`define PTOC_MAP_SVH

// ---------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------
`define PTOC_ADDR_OPT0       8'h3c
`define PTOC_ADDR_OPT1       8'h3d
`define PTOC_OPT0_RESET      16'h4b54
`define PTOC_OPT1_RESET      16'h8124
`define PTOC_OPT0_WMASK      16'hfffe
`define PTOC_OPT1_WMASK      16'hff7f

// ---------------------------------------------------------------------
// Fields of option zero, and the source enable field of option one
// ---------------------------------------------------------------------
`define PTOC_F_CRIT_THR      15:11
`define PTOC_F_CRIT_DG       10:9
`define PTOC_F_OVC_SEL       8
`define PTOC_F_SYSV_THR      7:6
`define PTOC_F_EXT_EN        5
`define PTOC_F_PULSE_W       4:3
`define PTOC_F_HOST_CLR      2
`define PTOC_F_NOM_DG        1
`define PTOC_F_ENV           6:0

// ---------------------------------------------------------------------
// Threshold arithmetic
// ---------------------------------------------------------------------
`define PTOC_CRIT_BASE_PCT   10'h069
`define PTOC_CRIT_STEP_PCT   10'h005
`define PTOC_CRIT_MIN_PCT    10'h06e
`define PTOC_CRIT_CLAMP_PCT  10'h0e6
`define PTOC_CRIT_LIN_MAX    5'h19
`define PTOC_CRIT_OOR        5'h1f
`define PTOC_ILIM_CLAMP      7'h38
`define PTOC_NOM_PCT         8'h6e

// ---------------------------------------------------------------------
// Times as printed, and clock period
// ---------------------------------------------------------------------
`define PTOC_CLK_NS          200
`define PTOC_CLK_PERIOD_NS   5
`define PTOC_CRIT_DG0_US     10
`define PTOC_CRIT_DG1_US     100
`define PTOC_CRIT_DG2_US     400
`define PTOC_CRIT_DG3_US     800
`define PTOC_SYSV_DG_US      20
`define PTOC_NOM_DG0_MS      1
`define PTOC_NOM_DG1_MS      50
`define PTOC_PW0_US          100
`define PTOC_PW1_MS          1
`define PTOC_PW2_MS          12
`define PTOC_PW3_MS          6
`define PTOC_NS_PER_US       1000
`define PTOC_NS_PER_MS       1000000

`endif

/* File: logic/ptoc_pkg.sv */
// Purpose: Types shared by the throttle option block
// Assumes: Nothing beyond the map header
// Notes:   Types only
package ptoc_pkg;

  typedef logic [9:0]  ptoc_pct_t;
  typedef logic [23:0] ptoc_cnt_t;

  typedef enum logic [1:0] {
    PTOC_IDLE,
    PTOC_TIMED,
    PTOC_HELD
  } ptoc_thr_state_t;

endpackage

/* File: logic/ptoc_deglitch.sv */
// Purpose: Level deglitch; output rises after input held for a count
// Assumes: Input already synchronised to clk_sys
// Notes:   Output drops in the cycle after the input drops
`timescale 1ns/1ps
module ptoc_deglitch (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Level and hold count
  input  wire logic             level_in,
  input  wire ptoc_pkg::ptoc_cnt_t hold_cycles,
  // Qualified level
  output logic                  hit_r
);
  import ptoc_pkg::*;

  ptoc_cnt_t cnt_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 24'h000000;
    end else if (!level_in) begin
      cnt_r <= 24'h000000;
    end else if (cnt_r < hold_cycles) begin
      cnt_r <= cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= level_in && (cnt_r + 24'h000001 >= hold_cycles);
    end
  end

endmodule

/* File: logic/ptoc_top.sv */
// Purpose: Throttle option registers, comparator deglitch, throttle pulse
// Assumes: Analog comparators drive raw levels; register port is same clock
// Notes:   Threshold outputs steer the analog comparators
`timescale 1ns/1ps
`include "ptoc_map.svh"
module ptoc_top #(
  parameter int unsigned CRIT_DG1_CYC =
    (`PTOC_CRIT_DG1_US * `PTOC_NS_PER_US + `PTOC_CLK_PERIOD_NS - 1)
    / `PTOC_CLK_PERIOD_NS,
  parameter int unsigned CRIT_DG2_CYC =
    (`PTOC_CRIT_DG2_US * `PTOC_NS_PER_US + `PTOC_CLK_PERIOD_NS - 1)
    / `PTOC_CLK_PERIOD_NS,
  parameter int unsigned CRIT_DG3_CYC =
    (`PTOC_CRIT_DG3_US * `PTOC_NS_PER_US + `PTOC_CLK_PERIOD_NS - 1)
    / `PTOC_CLK_PERIOD_NS,
  parameter int unsigned NOM_DG0_CYC =
    `PTOC_NOM_DG0_MS * `PTOC_NS_PER_MS / `PTOC_CLK_PERIOD_NS,
  parameter int unsigned NOM_DG1_CYC =
    `PTOC_NOM_DG1_MS * `PTOC_NS_PER_MS / `PTOC_CLK_PERIOD_NS,
  parameter int unsigned PW0_CYC =
    (`PTOC_PW0_US * `PTOC_NS_PER_US + `PTOC_CLK_PERIOD_NS - 1)
    / `PTOC_CLK_PERIOD_NS,
  parameter int unsigned PW1_CYC =
    (`PTOC_PW1_MS * `PTOC_NS_PER_MS + `PTOC_CLK_PERIOD_NS - 1)
    / `PTOC_CLK_PERIOD_NS,
  parameter int unsigned PW2_CYC =
    (`PTOC_PW2_MS * `PTOC_NS_PER_MS + `PTOC_CLK_PERIOD_NS - 1)
    / `PTOC_CLK_PERIOD_NS,
  parameter int unsigned PW3_CYC =
    (`PTOC_PW3_MS * `PTOC_NS_PER_MS + `PTOC_CLK_PERIOD_NS - 1)
    / `PTOC_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_rd,
  output logic [15:0]             reg_rdata_r,
  // Charger context
  input  wire logic [6:0]         input_current_limit_setting,
  input  wire logic               one_cell,
  input  wire logic               adapter_present,
  // Raw analog comparator levels
  input  wire logic               crit_above_raw,
  input  wire logic               nom_above_raw,
  input  wire logic               sysv_below_raw,
  input  wire logic               ovc_above_raw,
  // Other throttle sources, one-cycle pulses
  input  wire logic               indep_cmp_event,
  input  wire logic               discharge_event,
  input  wire logic               batpres_event,
  input  wire logic               acok_event,
  // Comparator settings
  output ptoc_pkg::ptoc_pct_t     crit_threshold_pct_r,
  output logic                    crit_out_of_range_r,
  output logic [10:0]             ovc_threshold_pct_r,
  output logic [7:0]              nom_threshold_pct_r,
  output logic [12:0]             sysv_threshold_mv_r,
  // Qualified events
  output logic                    crit_event_r,
  output logic                    nom_event_r,
  output logic                    sysv_event_r,
  output logic                    ovc_event_r,
  // Throttle pin, low active
  output logic                    processor_throttle_output_n_r
);
  import ptoc_pkg::*;

  // ---------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------
  function automatic ptoc_pct_t crit_pct(input logic [4:0] code,
                                         input logic [6:0] ilim);
    ptoc_pct_t p;
    p = `PTOC_CRIT_MIN_PCT;
    case (code)
      5'h00, 5'h01: p = `PTOC_CRIT_MIN_PCT;
      5'h1a: p = 10'h0fa;
      5'h1b: p = 10'h12c;
      5'h1c: p = 10'h15e;
      5'h1d: p = 10'h190;
      5'h1e: p = 10'h1c2;
      5'h1f: p = 10'h000;
      default: p = `PTOC_CRIT_BASE_PCT
                   + `PTOC_CRIT_STEP_PCT * {5'h00, code};
    endcase
    if (ilim > `PTOC_ILIM_CLAMP && code > `PTOC_CRIT_LIN_MAX
        && code != `PTOC_CRIT_OOR) begin
      p = `PTOC_CRIT_CLAMP_PCT;
    end
    return p;
  endfunction

  function automatic ptoc_cnt_t to_cnt(input int unsigned c);
    return c[23:0];
  endfunction

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  logic [15:0] opt0_r;
  logic [15:0] opt1_r;
  logic        wr0;
  logic        wr1;
  logic        host_clear_req;

  assign wr0 = reg_wr && reg_addr == `PTOC_ADDR_OPT0;
  assign wr1 = reg_wr && reg_addr == `PTOC_ADDR_OPT1;
  assign host_clear_req = !opt0_r[`PTOC_F_HOST_CLR]
                          && opt0_r[`PTOC_F_EXT_EN];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      opt0_r <= `PTOC_OPT0_RESET;
    end else if (wr0) begin
      opt0_r <= reg_wdata & `PTOC_OPT0_WMASK;
    end else if (!opt0_r[`PTOC_F_HOST_CLR]) begin
      opt0_r[`PTOC_F_HOST_CLR] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      opt1_r <= `PTOC_OPT1_RESET;
    end else if (wr1) begin
      opt1_r <= reg_wdata & `PTOC_OPT1_WMASK;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `PTOC_ADDR_OPT0: reg_rdata_r <= opt0_r;
        `PTOC_ADDR_OPT1: reg_rdata_r <= opt1_r;
        default:         reg_rdata_r <= 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Thresholds
  // ---------------------------------------------------------------------
  ptoc_pct_t crit_pct_now;

  assign crit_pct_now = crit_pct(opt0_r[`PTOC_F_CRIT_THR],
                                 input_current_limit_setting);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      crit_threshold_pct_r <= 10'h000;
      crit_out_of_range_r  <= 1'b0;
      ovc_threshold_pct_r  <= 11'h000;
      nom_threshold_pct_r  <= 8'h00;
    end else begin
      crit_threshold_pct_r <= crit_pct_now;
      crit_out_of_range_r  <= opt0_r[`PTOC_F_CRIT_THR] == `PTOC_CRIT_OOR;
      nom_threshold_pct_r  <= `PTOC_NOM_PCT;
      if (opt0_r[`PTOC_F_OVC_SEL]) begin
        ovc_threshold_pct_r <= {crit_pct_now, 1'b0};
      end else begin
        ovc_threshold_pct_r <= 11'(({3'h0, crit_pct_now} * 13'h0005)
                               >> 2);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sysv_threshold_mv_r <= 13'h0000;
    end else begin
      case ({one_cell, opt0_r[`PTOC_F_SYSV_THR]})
        3'b000:  sysv_threshold_mv_r <= 13'h1676;
        3'b001:  sysv_threshold_mv_r <= 13'h1770;
        3'b010:  sysv_threshold_mv_r <= 13'h186a;
        3'b011:  sysv_threshold_mv_r <= 13'h1964;
        3'b100:  sysv_threshold_mv_r <= 13'h0b22;
        3'b101:  sysv_threshold_mv_r <= 13'h0c1c;
        3'b110:  sysv_threshold_mv_r <= 13'h0d16;
        default: sysv_threshold_mv_r <= 13'h0e10;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------------
  logic [3:0] raw_meta_r;
  logic [3:0] raw_sync_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      raw_meta_r <= 4'h0;
      raw_sync_r <= 4'h0;
    end else begin
      raw_meta_r <= {ovc_above_raw, sysv_below_raw, nom_above_raw,
                     crit_above_raw};
      raw_sync_r <= raw_meta_r;
    end
  end

  // ---------------------------------------------------------------------
  // Deglitch
  // ---------------------------------------------------------------------
  ptoc_cnt_t crit_hold;
  ptoc_cnt_t nom_hold;
  ptoc_cnt_t sysv_hold;
  ptoc_cnt_t pulse_hold;
  logic      crit_hit;
  logic      nom_hit;
  logic      sysv_hit;

  always_comb begin
    case (opt0_r[`PTOC_F_CRIT_DG])
      2'b00:   crit_hold = to_cnt((`PTOC_CRIT_DG0_US * `PTOC_NS_PER_US
                          + `PTOC_CLK_PERIOD_NS - 1) / `PTOC_CLK_PERIOD_NS);
      2'b01:   crit_hold = to_cnt(CRIT_DG1_CYC);
      2'b10:   crit_hold = to_cnt(CRIT_DG2_CYC);
      default: crit_hold = to_cnt(CRIT_DG3_CYC);
    endcase
  end

  assign nom_hold = opt0_r[`PTOC_F_NOM_DG] ? to_cnt(NOM_DG1_CYC)
                                           : to_cnt(NOM_DG0_CYC);
  assign sysv_hold = to_cnt(`PTOC_SYSV_DG_US * `PTOC_NS_PER_US
                            / `PTOC_CLK_PERIOD_NS);

  always_comb begin
    case (opt0_r[`PTOC_F_PULSE_W])
      2'b00:   pulse_hold = to_cnt(PW0_CYC);
      2'b01:   pulse_hold = to_cnt(PW1_CYC);
      2'b10:   pulse_hold = to_cnt(PW2_CYC);
      default: pulse_hold = to_cnt(PW3_CYC);
    endcase
  end

  ptoc_deglitch u_crit_dg (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .level_in    (raw_sync_r[0] && !crit_out_of_range_r),
    .hold_cycles (crit_hold),
    .hit_r       (crit_hit)
  );

  ptoc_deglitch u_nom_dg (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .level_in    (raw_sync_r[1]),
    .hold_cycles (nom_hold),
    .hit_r       (nom_hit)
  );

  ptoc_deglitch u_sysv_dg (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .level_in    (raw_sync_r[2]),
    .hold_cycles (sysv_hold),
    .hit_r       (sysv_hit)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      crit_event_r <= 1'b0;
      nom_event_r  <= 1'b0;
      sysv_event_r <= 1'b0;
      ovc_event_r  <= 1'b0;
    end else begin
      crit_event_r <= crit_hit;
      nom_event_r  <= nom_hit;
      sysv_event_r <= sysv_hit;
      ovc_event_r  <= raw_sync_r[3];
    end
  end

  // ---------------------------------------------------------------------
  // Throttle sources
  // ---------------------------------------------------------------------
  logic [6:0] src_pulse;
  logic [6:0] src_mask;
  logic       trigger;

  assign src_pulse = {indep_cmp_event,
                      crit_hit && !crit_event_r,
                      nom_hit && !nom_event_r,
                      discharge_event,
                      sysv_hit && !sysv_event_r,
                      batpres_event,
                      acok_event};
  assign src_mask = opt1_r[`PTOC_F_ENV]
                    & (adapter_present ? 7'h7f : 7'h4c);
  assign trigger = |(src_pulse & src_mask);

  // ---------------------------------------------------------------------
  // Throttle pulse
  // ---------------------------------------------------------------------
  ptoc_thr_state_t thr_state_r;
  ptoc_cnt_t       pw_cnt_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      thr_state_r <= PTOC_IDLE;
    end else begin
      case (thr_state_r)
        PTOC_IDLE: begin
          if (trigger) begin
            thr_state_r <= opt0_r[`PTOC_F_EXT_EN] ? PTOC_HELD
                                                  : PTOC_TIMED;
          end
        end
        PTOC_TIMED: begin
          if (trigger && opt0_r[`PTOC_F_EXT_EN]) begin
            thr_state_r <= PTOC_HELD;
          end else if (!trigger && pw_cnt_r + 24'h000001 >= pulse_hold) begin
            thr_state_r <= PTOC_IDLE;
          end
        end
        PTOC_HELD: begin
          if (host_clear_req && !trigger) begin
            thr_state_r <= PTOC_IDLE;
          end
        end
        default: thr_state_r <= PTOC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pw_cnt_r <= 24'h000000;
    end else if (trigger || thr_state_r != PTOC_TIMED) begin
      pw_cnt_r <= 24'h000000;
    end else begin
      pw_cnt_r <= pw_cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      processor_throttle_output_n_r <= 1'b1;
    end else begin
      processor_throttle_output_n_r <= !(trigger
        || (thr_state_r == PTOC_TIMED
            && pw_cnt_r + 24'h000001 < pulse_hold)
        || (thr_state_r == PTOC_HELD && !host_clear_req));
    end
  end

endmodule

/* File: tb/ptoc_chk.sv */
// Purpose: Port checks on the throttle option block
// Assumes: One clock domain, reset low active
// Notes:   Bound to ptoc_top below
`timescale 1ns/1ps
module ptoc_chk #(
  parameter int unsigned PW0_CYC = 30
) (
  input wire logic                clk_sys,
  input wire logic                reset_n,
  input wire logic [7:0]          reg_addr,
  input wire logic                reg_wr,
  input wire logic [15:0]         reg_wdata,
  input wire logic                reg_rd,
  input wire logic [15:0]         reg_rdata_r,
  input wire logic [6:0]          input_current_limit_setting,
  input wire logic                crit_above_raw,
  input wire ptoc_pkg::ptoc_pct_t crit_threshold_pct_r,
  input wire logic                crit_out_of_range_r,
  input wire logic [10:0]         ovc_threshold_pct_r,
  input wire logic [7:0]          nom_threshold_pct_r,
  input wire logic                crit_event_r,
  input wire logic                processor_throttle_output_n_r
);
  import ptoc_pkg::*;
  int unsigned low_cnt_r;
  logic        ext_r;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // Low time of the pin, extension bit as written
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_r <= 0;
    end else if (processor_throttle_output_n_r) begin
      low_cnt_r <= 0;
    end else begin
      low_cnt_r <= low_cnt_r + 1;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_r <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h3c) begin
      ext_r <= reg_wdata[5];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_RD_UNMAPPED: assert property (
    reg_rd && reg_addr != 8'h3c && reg_addr != 8'h3d |=>
      reg_rdata_r == 16'h0000) else $error("unmapped read not zero");
  AST_RSV_BIT: assert property (
    reg_rd && reg_addr == 8'h3c |=> !reg_rdata_r[0])
    else $error("reserved bit read high");
  AST_CRIT_OOR: assert property (
    crit_out_of_range_r |-> crit_threshold_pct_r == 10'h000)
    else $error("out of range code gave a threshold");
  AST_CRIT_CLAMP: assert property (
    (input_current_limit_setting > 7'h38) [*3] |->
      crit_threshold_pct_r <= 10'h0e6) else $error("clamp missed");
  AST_NOM_PCT: assert property (
    $past(reset_n) |-> nom_threshold_pct_r == 8'h6e)
    else $error("nominal threshold wrong");
  AST_OVC_RATIO: assert property (
    $past(reset_n) && $stable(crit_threshold_pct_r) |->
      ovc_threshold_pct_r == {crit_threshold_pct_r, 1'b0} ||
      12'(ovc_threshold_pct_r) ==
        ((12'(crit_threshold_pct_r) * 12'h005) >> 2))
    else $error("overcurrent level not 125 or 200 percent");
  AST_EVT_DROP: assert property (
    !crit_above_raw [*6] |-> !crit_event_r)
    else $error("critical event outlived its cause");
  AST_PIN_MIN: assert property (
    $rose(processor_throttle_output_n_r) |-> low_cnt_r >= PW0_CYC - 1)
    else $error("throttle pulse too short");
  AST_HOST_CLR: assert property (
    reg_wr && reg_addr == 8'h3c && !reg_wdata[2] && ext_r &&
      !processor_throttle_output_n_r |->
      ##[1:3] processor_throttle_output_n_r)
    else $error("host clear did not release pin");

  cover property ($rose(processor_throttle_output_n_r));
  cover property ($rose(crit_event_r));
  cover property (crit_out_of_range_r);
endmodule

bind ptoc_top ptoc_chk #(.PW0_CYC(PW0_CYC)) ptoc_chk_i (
  .clk_sys, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata_r, .input_current_limit_setting, .crit_above_raw,
  .crit_threshold_pct_r, .crit_out_of_range_r, .ovc_threshold_pct_r,
  .nom_threshold_pct_r, .crit_event_r, .processor_throttle_output_n_r
);

/* File: tb/ptoc_cpu_model.sv */
// Purpose: Processor side of the throttle pin
// Assumes: Pin sampled on clk_sys
// Notes:   Reports the length of the last low pulse
`timescale 1ns/1ps
module ptoc_cpu_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Throttle pin
  input  wire logic processor_throttle_output_n_r,
  // Last pulse length in cycles
  output int        low_width_r
);
  int run_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_r       <= 0;
      low_width_r <= 0;
    end else if (!processor_throttle_output_n_r) begin
      run_r <= run_r + 1;
    end else if (run_r != 0) begin
      low_width_r <= run_r;
      run_r       <= 0;
    end
  end
endmodule

/* File: tb/processor_throttle_option_control_bench.sv */
// Purpose: Register, threshold, deglitch and throttle tests
// Assumes: Counts shortened through parameters
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module processor_throttle_option_control_bench;
  import ptoc_pkg::*;
  localparam int unsigned DG [4] = '{2000, 40, 60, 80};
  localparam int unsigned NG [2] = '{100, 120};
  localparam int unsigned PW [4] = '{30, 50, 70, 90};
  localparam int          CODES [10] = '{0, 1, 2, 9, 25, 26, 27, 28, 29, 30};
  logic        clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
  logic        one_cell = 0, adapter_present = 1, ovc_raw = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata_r, rd_v;
  logic [6:0]  ilim = 7'h38;
  logic [2:0]  raw = 3'h0;
  wire  [2:0]  evt;
  logic [3:0]  src = 4'h0;
  ptoc_pct_t   crit_pct;
  logic [10:0] ovc_pct;
  logic [7:0]  nom_pct;
  logic [12:0] sysv_mv;
  logic        oor, ovc_evt, pin_n;
  int          n_fail = 0, n_compared = 0, cyc = 0, low_w, e;

  always #2.5 clk_sys = ~clk_sys;

  ptoc_top #(.CRIT_DG1_CYC(DG[1]), .CRIT_DG2_CYC(DG[2]),
    .CRIT_DG3_CYC(DG[3]), .NOM_DG0_CYC(NG[0]), .NOM_DG1_CYC(NG[1]),
    .PW0_CYC(PW[0]), .PW1_CYC(PW[1]), .PW2_CYC(PW[2]), .PW3_CYC(PW[3])
  ) ptoc_top_i (.clk_sys, .reset_n, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata_r, .input_current_limit_setting(ilim), .one_cell,
    .adapter_present, .crit_above_raw(raw[0]), .nom_above_raw(raw[1]),
    .sysv_below_raw(raw[2]), .ovc_above_raw(ovc_raw),
    .indep_cmp_event(src[3]), .discharge_event(src[2]),
    .batpres_event(src[1]), .acok_event(src[0]),
    .crit_threshold_pct_r(crit_pct), .crit_out_of_range_r(oor),
    .ovc_threshold_pct_r(ovc_pct), .nom_threshold_pct_r(nom_pct),
    .sysv_threshold_mv_r(sysv_mv), .crit_event_r(evt[0]),
    .nom_event_r(evt[1]), .sysv_event_r(evt[2]), .ovc_event_r(ovc_evt),
    .processor_throttle_output_n_r(pin_n));
  ptoc_cpu_model ptoc_cpu_model_i (.clk_sys, .reset_n,
    .processor_throttle_output_n_r(pin_n), .low_width_r(low_w));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    idle(1);
    reg_wr = 0;
    idle(1);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1;
    idle(1);
    reg_rd = 0;
    idle(1);
    rd_v = reg_rdata_r;
  endtask
  task automatic fire(input int i);
    src[i] = 1;
    idle(1);
    src[i] = 0;
    idle(1);
  endtask
  task automatic wait_hi();
    for (int k = 0; k < 200 && pin_n !== 1'b1; k++)
      idle(1);
    idle(1);
  endtask
  task automatic lat(input int i, input int n, input string nm);
    int k;
    k = 0;
    raw[i] = 1;
    while (evt[i] !== 1'b1 && k < n + 20) begin
      idle(1);
      k++;
    end
    chk(nm, 16'(k >= n && k <= n + 8), 16'h0001);
    raw[i] = 0;
    idle(10);
  endtask
  function automatic int crit_exp(input int c, input bit clamp);
    int v;
    v = c < 2 ? 110 : c < 26 ? 105 + 5 * c : c == 26 ? 250 : 50 * c - 1050;
    return (clamp && v > 230) ? 230 : v;
  endfunction

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    idle(5);
    reset_n = 1;
    idle(2);
    rd(8'h3c);
    chk("opt0 reset", rd_v, 16'h4b54);
    rd(8'h3d);
    chk("opt1 reset", rd_v, 16'h8124);
    chk("crit pct", 16'(crit_pct), 16'h0096);
    chk("ovc pct", 16'(ovc_pct), 16'h012c);
    chk("nom pct", 16'(nom_pct), 16'h006e);
    chk("sysv mv", 16'(sysv_mv), 16'h1770);
    rd(8'h3e);
    chk("unmapped", rd_v, 16'h0000);
    wr(8'h3c, 16'hffff);
    wr(8'h3d, 16'hffff);
    wr(8'h3e, 16'h1234);
    rd(8'h3c);
    chk("opt0 rsv", rd_v, 16'hfffe);
    chk("crit oor", {oor, 5'h00, crit_pct}, 16'h8000);
    rd(8'h3d);
    chk("opt1 rsv", rd_v, 16'hff7f);
    for (int j = 0; j < 2; j++) begin
      ilim = j ? 7'h39 : 7'h38;
      foreach (CODES[c]) for (int s = 0; s < 2; s++) begin
        wr(8'h3c, {5'(CODES[c]), 2'b01, s[0], 8'h54});
        idle(2);
        e = crit_exp(CODES[c], j[0]);
        chk("crit pct", 16'(crit_pct), 16'(e));
        chk("ovc pct", 16'(ovc_pct), 16'(s ? 2 * e : e * 5 / 4));
      end
    end
    for (int k = 0; k < 8; k++) begin
      one_cell = k[2];
      wr(8'h3c, {8'h4b, k[1:0], 6'h14});
      idle(2);
      e = (k[2] ? 2850 : 5750) + 250 * (k % 4);
      chk("sysv mv", 16'(sysv_mv), 16'(e));
    end
    one_cell = 0;
    for (int d = 0; d < 4; d++) begin
      wr(8'h3c, {5'h09, d[1:0], 9'h154});
      lat(0, DG[d], "crit deglitch");
    end
    raw[0] = 1;
    idle(DG[3] / 2);
    raw[0] = 0;
    idle(10);
    chk("crit glitch", 16'(evt[0]), 16'h0000);
    for (int n = 0; n < 2; n++) begin
      wr(8'h3c, {8'h4b, 6'h15, n[0], 1'b0});
      lat(1, NG[n], "nom deglitch");
    end
    lat(2, 4000, "sysv deglitch");
    ovc_raw = 1;
    idle(4);
    chk("ovc event", 16'(ovc_evt), 16'h0001);
    ovc_raw = 0;
    wr(8'h3d, 16'h8101);
    wait_hi();
    for (int p = 0; p < 4; p++) begin
      wr(8'h3c, {8'h4b, 3'b010, p[1:0], 3'b100});
      fire(0);
      chk("pin low", 16'(pin_n), 16'h0000);
      wait_hi();
      e = (low_w >= PW[p] && low_w <= PW[p] + 3);
      chk("pulse width", 16'(e), 16'h0001);
    end
    wr(8'h3c, 16'h4b74);
    fire(0);
    idle(PW[3] + 20);
    chk("held low", 16'(pin_n), 16'h0000);
    wr(8'h3c, 16'h4b70);
    chk("cleared", 16'(pin_n), 16'h0001);
    rd(8'h3c);
    chk("clear idle", rd_v, 16'h4b74);
    wr(8'h3c, 16'h4b54);
    fire(0);
    wr(8'h3c, 16'h4b50);
    chk("clear ignored", 16'(pin_n), 16'h0000);
    wait_hi();
    wr(8'h3d, 16'h8100);
    fire(0);
    chk("env off", 16'(pin_n), 16'h0001);
    foreach (src[i]) begin
      e = i == 3 ? 6 : i == 2 ? 3 : i;
      wr(8'h3d, 16'h8100 | (16'h0001 << e));
      fire(i);
      chk("source fires", 16'(pin_n), 16'h0000);
      wait_hi();
    end
    adapter_present = 0;
    wr(8'h3d, 16'h810b);
    fire(0);
    chk("adapter mask", 16'(pin_n), 16'h0001);
    fire(2);
    chk("discharge kept", 16'(pin_n), 16'h0000);
    wait_hi();
    end_sim();
  end
endmodule
